// >>> testbench/cftr_host_model.sv
/*
  Host processor model: byte register writes and reads on the port.
  Assumes the register bank takes strobes on rising core_clk.
*/
`default_nettype none
module cftr_host_model (
  input  wire logic       core_clk,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus; data left inverted so stale values never look valid
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'hFF;
  end

  //////////////////////////////////////////////////////////////////////////
  // One write; the caller sets the fitted bit when a ship switch exists
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // One read; data taken just after the edge that accepts the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule // cftr_host_model
`default_nettype wire

// >>> testbench/testbench.sv
/*
  Self-checking bench for the feature and tracking register pair.
  Assumes one 20 MHz clock and a 2-cycle millisecond tick.
*/
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  errors++; $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module testbench;
  import cftr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int TK = 2; // Short tick keeps the interval run short
  logic core_clk, rst, clk_en, reg_wr, reg_rd, wdog, rcmd, ocv, fit;
  logic [7:0]  addr, wdata, rdata, d;
  logic [1:0]  sreq, ship, lim;
  logic [15:0] ocl, lvl;
  logic oc, sen, iil, eil, stop, req, upd;
  int errors, comparisons;

  cftr_host_model host (.core_clk(core_clk), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata));

  cftr_regs #(.TICK_CYC(TK)) DUT (.core_clk(core_clk), .rst(rst),
    .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .wdog_expire(wdog),
    .reg_reset_cmd(rcmd), .ship_drive_req(sreq),
    .open_circuit_level(ocl), .open_circuit_valid(ocv),
    .ship_switch_fitted(fit), .ship_drive_ctrl(ship),
    .batt_discharge_overcurrent_en(oc), .batt_discharge_sense_en(sen),
    .batt_discharge_limit_sel(lim), .internal_input_current_limit_en(iil),
    .external_input_current_limit_en(eil), .converter_stop(stop),
    .open_circuit_sample_req(req), .level_update(upd),
    .input_voltage_regulation_level(lvl));

  // Clock at 50 ns
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  //////////////////////////////////////////////////////////////////////////
  // One-cycle pulse on the watchdog or reset-command input
  task automatic pulse(input bit w);
    @(posedge core_clk);
    if (w) wdog <= 1'b1; else rcmd <= 1'b1;
    @(posedge core_clk);
    wdog <= 1'b0;
    rcmd <= 1'b0;
  endtask

  // Values after power-on
  task automatic t_reset;
    host.rd(FEAT_OFS, d);
    `CHK("feat reset", 8'h16, d)
    host.rd(TRACK_OFS, d);
    `CHK("track reset", 8'hAA, d)
    `CHK("limit sel", 2'h2, lim)
    `CHK("sense off", 1'b0, sen)
    `CHK("int lim on", 1'b1, iil)
    `CHK("ext lim on", 1'b1, eil)
    `CHK("oc off", 1'b0, oc)
    `CHK("ship drive", 2'h0, ship)
    `CHK("fitted", 1'b0, fit)
  endtask

  // Locked fields without a ship switch, open with one
  task automatic t_lock;
    host.wr(FEAT_OFS, 8'h7F);
    #1 `CHK("oc locked", 1'b0, oc)
    `CHK("drive locked", 2'h0, ship)
    host.rd(FEAT_OFS, d);
    `CHK("feat locked", 8'h3E, d)
    host.wr(FEAT_OFS, 8'hC1);
    #1 `CHK("oc open", 1'b1, oc)
    `CHK("drive open", 2'h3, ship)
    `CHK("fitted set", 1'b1, fit)
    host.rd(FEAT_OFS, d);
    `CHK("feat fitted", 8'h81, d)
  endtask

  // Every limit code reaches its output
  task automatic t_limit;
    for (int c = 0; c < 4; c++) begin
      host.wr(FEAT_OFS, 8'h80 | 8'(c << 3));
      #1 `CHK("limit code", 2'(c), lim)
    end
  endtask

  // Watchdog keeps pin limit and tracking; command restores all but fitted
  task automatic t_wdog;
    host.wr(FEAT_OFS, 8'hB9);
    host.wr(TRACK_OFS, 8'h54);
    host.wr(8'h16, 8'hFF);
    host.rd(8'h16, d);
    `CHK("unmapped", 8'h00, d)
    pulse(1'b1);
    host.rd(FEAT_OFS, d);
    `CHK("feat wdog", 8'h94, d)
    host.rd(TRACK_OFS, d);
    `CHK("track wdog", 8'h54, d)
    host.wr(FEAT_OFS, 8'hA1);
    pulse(1'b0);
    host.rd(FEAT_OFS, d);
    `CHK("feat cmd", 8'h96, d)
    host.rd(TRACK_OFS, d);
    `CHK("track cmd", 8'hAA, d)
    // Clock enable low: write and watchdog must leave no trace
    @(posedge core_clk);
    clk_en <= 1'b0;
    host.wr(FEAT_OFS, 8'h00);
    pulse(1'b1);
    @(posedge core_clk);
    clk_en <= 1'b1;
    host.rd(FEAT_OFS, d);
    `CHK("feat frozen", 8'h96, d)
  endtask

  // Shortest interval and settle, fraction code 0
  task automatic t_track;
    int n;
    host.wr(TRACK_OFS, 8'h01);
    n = 0;
    do begin @(posedge core_clk); #1 n++; end while (!stop && n < 70000);
    `CHK("interval", 1'b1, n >= 60000 - 10 && n <= 60000 + 10)
    n = 0;
    do begin @(posedge core_clk); #1 n++; end while (!req && n < 200);
    `CHK("settle", 1'b1, n >= 100 - 5 && n <= 100 + 5)
    `CHK("stopped", 1'b1, stop)
    `CHK("sample req", 1'b1, req)
    @(posedge core_clk);
    ocv <= 1'b1;
    ocl <= 16'h1000;
    @(posedge core_clk);
    ocv <= 1'b0;
    ocl <= 16'hEFFF;
    n = 0;
    do begin @(posedge core_clk); #1 n++; end while (!upd && n < 5);
    `CHK("level", 16'h0900, lvl)
    `CHK("update", 1'b1, upd)
    `CHK("req done", 1'b0, req)
    `CHK("resume", 1'b0, stop)
    host.wr(TRACK_OFS, 8'h00);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic results;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog on the whole run
  initial begin
    #4500000;
    errors++;
    results();
  end

  // Main sequence
  initial begin
    errors = 0;
    comparisons = 0;
    rst = 1'b1;
    clk_en = 1'b1;
    wdog = 1'b0;
    rcmd = 1'b0;
    sreq = 2'h3;
    ocl = 16'hFFFF;
    ocv = 1'b0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_lock();
    t_limit();
    t_wdog();
    t_track();
    results();
  end
endmodule // testbench
`default_nettype wire

// >>> verilog/cftr_pkg.sv
/*
  Constants for the charger feature and tracking register pair: offsets,
  field positions, values after reset, timing and sequencer states.
  Assumes a single 20 MHz core clock.
*/
`default_nettype none
package cftr_pkg;
  // Register offsets and values after reset
  localparam logic [7:0] FEAT_OFS  = 8'h14;
  localparam logic [7:0] TRACK_OFS = 8'h15;
  localparam logic [7:0] FEAT_RST  = 8'h16;
  localparam logic [7:0] TRACK_RST = 8'hAA;
  localparam logic [7:0] FEAT_RSVD_MASK = 8'h40;

  // Feature register field positions
  localparam int FEAT_FITTED = 7;
  localparam int FEAT_SENSE  = 5;
  localparam int FEAT_LIM_LO = 3;
  localparam int FEAT_INT    = 2;
  localparam int FEAT_EXT    = 1;
  localparam int FEAT_OC     = 0;

  // Tracking register field positions
  localparam int TRK_FRAC_LO = 5;
  localparam int TRK_DLY_LO  = 3;
  localparam int TRK_RATE_LO = 1;
  localparam int TRK_EN      = 0;

  // Fraction is (FRAC_BASE + code) / 16
  localparam logic [4:0] FRAC_BASE = 5'h09;

  // Timing: a millisecond tick drives all slow counters
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [20:0] SETTLE_MS_0 = 21'h32;     // 50 ms
  localparam logic [20:0] SETTLE_MS_1 = 21'h12C;    // 300 ms
  localparam logic [20:0] SETTLE_MS_2 = 21'h7D0;    // 2 s
  localparam logic [20:0] SETTLE_MS_3 = 21'h1388;   // 5 s
  localparam logic [20:0] RATE_MS_0   = 21'h7530;   // 30 s
  localparam logic [20:0] RATE_MS_1   = 21'h1D4C0;  // 2 min
  localparam logic [20:0] RATE_MS_2   = 21'h927C0;  // 10 min
  localparam logic [20:0] RATE_MS_3   = 21'h1B7740; // 30 min

  // Tracking sequencer states
  typedef enum logic [3:0] {
    ST_RUN    = 4'b0001,
    ST_SETTLE = 4'b0010,
    ST_SAMPLE = 4'b0100,
    ST_UPDATE = 4'b1000
  } cftr_state_t;
endpackage
`default_nettype wire

// >>> verilog/cftr_regs.sv
/*
  Charger feature control and power point tracking control registers,
  with the tracking sequencer behind them.
  Assumes a synchronous byte-wide register port driven by the host
  interface logic, and one-cycle pulses for watchdog expiry and the
  register-reset command.
*/
// Functional notes
// - Feature register 0x14, reset 0x16, bit6 zero
// - Unfitted ship switch locks overcurrent, drive at zero
// - Fitted ship switch unlocks those fields
// - Sense enable off, cleared by watchdog and reset
// - Limit select 3A/4A/5A/off, resets to code 2
// - Internal current limit on, restored by both
// - External pin limit on, restored only by reset
// - Overcurrent protection off, cleared by both
// - Tracking register 0x15, reset 0xAA, all writable
// - Regulation level is sample times chosen fraction
// - Settle delay 50ms/300ms/2s/5s before sampling
// - Sample interval 30s/2min/10min/30min
// - Tracking enable bit, off by default
// - Tracking fields restored only by register reset
`default_nettype none
module cftr_regs #(
  parameter int TICK_CYC = cftr_pkg::TICK_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output var  logic [7:0]  reg_rdata,
  input  wire logic        wdog_expire,
  input  wire logic        reg_reset_cmd,
  input  wire logic [1:0]  ship_drive_req,
  input  wire logic [15:0] open_circuit_level,
  input  wire logic        open_circuit_valid,
  output var  logic        ship_switch_fitted,
  output var  logic [1:0]  ship_drive_ctrl,
  output var  logic        batt_discharge_overcurrent_en,
  output var  logic        batt_discharge_sense_en,
  output var  logic [1:0]  batt_discharge_limit_sel,
  output var  logic        internal_input_current_limit_en,
  output var  logic        external_input_current_limit_en,
  output var  logic        converter_stop,
  output var  logic        open_circuit_sample_req,
  output var  logic        level_update,
  output var  logic [15:0] input_voltage_regulation_level
);
  import cftr_pkg::*;

  logic [7:0] feat;
  logic [7:0] track;
  logic [7:0] next_feat;
  logic [7:0] next_track;
  logic [7:0] wr_feat;
  logic       wr_feat_sel;
  logic       wr_track_sel;
  logic       rd_feat_sel;
  logic       rd_track_sel;
  logic [7:0] feat_wdog;

  cftr_track_if tif ();

  //////////////////////////////////////////////////////////////////////
  // Address decode
  assign wr_feat_sel  = reg_wr && (reg_addr == FEAT_OFS);
  assign wr_track_sel = reg_wr && (reg_addr == TRACK_OFS);
  assign rd_feat_sel  = reg_rd && (reg_addr == FEAT_OFS);
  assign rd_track_sel = reg_rd && (reg_addr == TRACK_OFS);

  // Written value with reserved bit dropped and ship lock applied; the
  // lock follows the fitted bit in the same write so one write unlocks
  assign wr_feat = {reg_wdata[FEAT_FITTED], 1'b0,
                    reg_wdata[5:1],
                    reg_wdata[FEAT_FITTED] & reg_wdata[FEAT_OC]};

  // Watchdog restores all feature fields except fitted and external
  assign feat_wdog = {feat[FEAT_FITTED], 1'b0,
                      FEAT_RST[FEAT_SENSE],
                      FEAT_RST[FEAT_LIM_LO+1:FEAT_LIM_LO],
                      FEAT_RST[FEAT_INT],
                      feat[FEAT_EXT],
                      FEAT_RST[FEAT_OC]};

  // Priority: register reset, then watchdog, then host write
  assign next_feat  = reg_reset_cmd ? {feat[FEAT_FITTED], FEAT_RST[6:0]} :
                      wdog_expire   ? feat_wdog :
                      wr_feat_sel   ? wr_feat : feat;
  // Watchdog has no effect on the tracking register
  assign next_track = reg_reset_cmd ? TRACK_RST :
                      wr_track_sel  ? reg_wdata : track;

  //////////////////////////////////////////////////////////////////////
  // Register storage
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      feat  <= FEAT_RST;
      track <= TRACK_RST;
    end else if (clk_en) begin
      feat  <= next_feat;
      track <= next_track;
    end
  end

  // Read port; unmapped offsets read zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      reg_rdata <= rd_feat_sel  ? (feat & ~FEAT_RSVD_MASK) :
                   rd_track_sel ? track : 8'h00;
    end
  end

  // Ship drive follows the request only with a fitted switch
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ship_drive_ctrl <= 2'h0;
    end else if (clk_en) begin
      ship_drive_ctrl <= next_feat[FEAT_FITTED] ? ship_drive_req
                                                : 2'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Field outputs come straight from the register flops
  assign ship_switch_fitted              = feat[FEAT_FITTED];
  // Stored bit is already gated by the fitted bit at write time
  assign batt_discharge_overcurrent_en   = feat[FEAT_OC];
  assign batt_discharge_sense_en         = feat[FEAT_SENSE];
  assign batt_discharge_limit_sel        = feat[FEAT_LIM_LO+1:FEAT_LIM_LO];
  assign internal_input_current_limit_en = feat[FEAT_INT];
  assign external_input_current_limit_en = feat[FEAT_EXT];

  // Tracking configuration out, sequencer state back
  assign tif.enable       = track[TRK_EN];
  assign tif.fraction     = track[TRK_FRAC_LO+2:TRK_FRAC_LO];
  assign tif.settle_sel   = track[TRK_DLY_LO+1:TRK_DLY_LO];
  assign tif.interval_sel = track[TRK_RATE_LO+1:TRK_RATE_LO];
  assign converter_stop   = tif.converter_stop;
  assign open_circuit_sample_req        = tif.sample_req;
  assign level_update                   = tif.level_update;
  assign input_voltage_regulation_level = tif.level;

  cftr_track #(
    .TICK_CYC (TICK_CYC)
  ) u_track (
    .core_clk  (core_clk),
    .rst       (rst),
    .clk_en    (clk_en),
    .voc_level (open_circuit_level),
    .voc_valid (open_circuit_valid),
    .tif       (tif.seq)
  );

  //////////////////////////////////////////////////////////////////////
  // Checks
  a_oc_locked: assert property (
    @(posedge core_clk) disable iff (rst)
    !ship_switch_fitted |-> !batt_discharge_overcurrent_en && !feat[FEAT_OC])
    else $error("overcurrent enable not locked");

  a_drive_locked: assert property (
    @(posedge core_clk) disable iff (rst)
    !ship_switch_fitted |-> ship_drive_ctrl == 2'h0)
    else $error("ship drive not locked");

  a_unlock_write: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && wr_feat_sel && !wdog_expire && !reg_reset_cmd &&
     reg_wdata[FEAT_FITTED] && reg_wdata[FEAT_OC])
    |=> batt_discharge_overcurrent_en)
    else $error("fitted switch did not unlock");

  a_wdog_restores: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && wdog_expire) |=> batt_discharge_limit_sel == 2'h2 &&
      !batt_discharge_sense_en && internal_input_current_limit_en &&
      !feat[FEAT_OC])
    else $error("watchdog restore wrong");

  a_wdog_keeps_ext: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && wdog_expire && !reg_reset_cmd) |=>
      $stable(external_input_current_limit_en))
    else $error("watchdog touched external limit enable");

  a_wdog_keeps_track: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && wdog_expire && !reg_reset_cmd && !wr_track_sel) |=>
      $stable(track))
    else $error("watchdog touched tracking register");

  a_regrst_defaults: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && reg_reset_cmd) |=> track == 8'hAA &&
      (feat & 8'h7F) == 8'h16)
    else $error("register reset defaults wrong");

  a_rsvd_reads_zero: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && rd_feat_sel) |=> !reg_rdata[6] &&
      reg_rdata[5:0] == $past(feat[5:0]))
    else $error("feature read back wrong");

  a_rsvd_stored_zero: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && wr_feat_sel) |=> !feat[6])
    else $error("reserved bit stored");

  a_lock_refused: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && wr_feat_sel && !wdog_expire && !reg_reset_cmd &&
     !reg_wdata[FEAT_FITTED]) |=> !feat[FEAT_OC] && ship_drive_ctrl == 2'h0)
    else $error("locked field accepted a write");

  a_ship_follows: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && next_feat[FEAT_FITTED]) |=>
      ship_drive_ctrl == $past(ship_drive_req))
    else $error("ship drive not passed when fitted");

  a_track_write: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && wr_track_sel && !reg_reset_cmd) |=>
      track == $past(reg_wdata))
    else $error("tracking write not stored");
endmodule // cftr_regs
`default_nettype wire

// >>> verilog/cftr_track.sv
/*
  Open-circuit sampling sequencer for power point tracking.
  Assumes the measurement front end raises voc_valid for one cycle with
  the sampled level while sample_req is high.
*/
`default_nettype none
module cftr_track #(
  parameter int TICK_CYC = cftr_pkg::TICK_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic [15:0] voc_level,
  input  wire logic        voc_valid,
  cftr_track_if.seq        tif
);
  import cftr_pkg::*;

  cftr_state_t state;
  cftr_state_t next_state;
  logic [31:0] pre_cnt;
  logic [20:0] ms_cnt;
  logic [15:0] voc_hold;
  logic        tick;
  logic [20:0] settle_ms;
  logic [20:0] rate_ms;
  logic        ms_done;
  logic [20:0] lim_ms;
  logic [20:0] scaled;

  //////////////////////////////////////////////////////////////////////
  // Selection and decode
  assign tick      = (pre_cnt == 32'(TICK_CYC - 1));
  assign settle_ms = (tif.settle_sel == 2'h0) ? SETTLE_MS_0 :
                     (tif.settle_sel == 2'h1) ? SETTLE_MS_1 :
                     (tif.settle_sel == 2'h2) ? SETTLE_MS_2 : SETTLE_MS_3;
  assign rate_ms   = (tif.interval_sel == 2'h0) ? RATE_MS_0 :
                     (tif.interval_sel == 2'h1) ? RATE_MS_1 :
                     (tif.interval_sel == 2'h2) ? RATE_MS_2 : RATE_MS_3;
  assign lim_ms    = (state == ST_SETTLE) ? settle_ms : rate_ms;
  assign ms_done   = tick && (ms_cnt >= lim_ms - 21'h1);
  // Fraction steps of 1/16 above 9/16; product fits 21 bits
  assign scaled    = 21'(voc_hold) * 21'(FRAC_BASE + {2'h0, tif.fraction});

  // Next state: disabling tracking aborts and resumes switching
  always_comb begin
    next_state = state;
    if (!tif.enable) begin
      next_state = ST_RUN;
    end else begin
      unique case (state)
        ST_RUN:    if (ms_done) next_state = ST_SETTLE;
        ST_SETTLE: if (ms_done) next_state = ST_SAMPLE;
        ST_SAMPLE: if (voc_valid) next_state = ST_UPDATE;
        ST_UPDATE: next_state = ST_RUN;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Millisecond prescaler and slow counter
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pre_cnt <= '0;
      ms_cnt  <= '0;
    end else if (clk_en) begin
      pre_cnt <= tick ? '0 : pre_cnt + 32'h1;
      if (next_state != state || !tif.enable) ms_cnt <= '0;
      else if (tick) ms_cnt <= ms_cnt + 21'h1;
    end
  end

  // Sequencer and its outputs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state              <= ST_RUN;
      voc_hold           <= '0;
      tif.converter_stop <= 1'b0;
      tif.sample_req     <= 1'b0;
      tif.level_update   <= 1'b0;
      tif.level          <= '0;
    end else if (clk_en) begin
      state              <= next_state;
      tif.converter_stop <= (next_state != ST_RUN);
      tif.sample_req     <= (next_state == ST_SAMPLE);
      tif.level_update   <= (state == ST_UPDATE) && tif.enable;
      if (state == ST_SAMPLE && voc_valid) voc_hold <= voc_level;
      if (state == ST_UPDATE && tif.enable) begin
        tif.level <= scaled[19:4];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_sampled;
    clk_en && state == ST_SAMPLE && voc_valid && tif.enable;
  endsequence

  property p_level;
    @(posedge core_clk) disable iff (rst)
    (s_sampled ##1 (clk_en && tif.enable)) |=>
      tif.level == 16'((21'(voc_hold) *
        (FRAC_BASE + {2'h0, tif.fraction})) >> 4);
  endproperty
  a_level_from_fraction: assert property (p_level)
    else $error("level not scaled by fraction");

  a_stop_while_sampling: assert property (
    @(posedge core_clk) disable iff (rst)
    tif.sample_req |-> tif.converter_stop)
    else $error("sampling while switching");

  a_idle_when_off: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && !tif.enable) |=> !tif.converter_stop && !tif.sample_req)
    else $error("sequence ran with tracking off");
endmodule // cftr_track
`default_nettype wire

// >>> verilog/cftr_track_if.sv
/*
  Carrier between the register bank and the tracking sequencer.
  Assumes both ends share core_clk.
*/
`default_nettype none
interface cftr_track_if;
  logic        enable;
  logic [2:0]  fraction;
  logic [1:0]  settle_sel;
  logic [1:0]  interval_sel;
  logic        converter_stop;
  logic        sample_req;
  logic        level_update;
  logic [15:0] level;
  modport regs (output enable, fraction, settle_sel, interval_sel,
                input converter_stop, sample_req, level_update, level);
  modport seq  (input enable, fraction, settle_sel, interval_sel,
                output converter_stop, sample_req, level_update, level);
endinterface
`default_nettype wire
